// ==== rtl/sssel_pkg.sv ====
package sssel_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_TX_HOLD = 8'h08;
  localparam logic [7:0] OFS_RX_HOLD = 8'h0C;

  // ----------------------------------------------------------------
  // Status register bit positions
  // ----------------------------------------------------------------
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_RX_FULL = 6;
  localparam int ST_OVERRUN = 5;
  localparam int ST_FRAMING = 4;
  localparam int ST_PARITY = 3;
  localparam int ST_TX_DONE = 2;
  localparam int ST_MP_RX = 1;
  localparam int ST_MP_TX = 0;
  localparam logic [7:0] STATUS_RESET = 8'h84;

  // ----------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------
  localparam int CT_CLK_LO = 0;
  localparam int CT_CLK_HI = 1;
  localparam int CT_TX_END_IE = 2;
  localparam int CT_RX_EN = 4;
  localparam int CT_TX_EN = 5;
  localparam int CT_SYNC_MODE = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Clock source selections
  // ----------------------------------------------------------------
  localparam logic [1:0] CKS_INTERNAL = 2'h0;
  localparam logic [1:0] CKS_INT_OUT = 2'h1;
  localparam logic [1:0] CKS_EXTERNAL = 2'h2;
  localparam logic [1:0] CKS_RESERVED = 2'h3;

  // ----------------------------------------------------------------
  // Synchroniser depth for pin inputs
  // ----------------------------------------------------------------
  localparam int SYNC_STAGES = 2;

endpackage

// ==== rtl/sssel_core.sv ====
// Function
// - Enable bit gates transmit-end request; reset 0.
// - Transmit-end when final bit due, no data.
// - Request drops when flags or enable clear.
// - Clock bits pick source and pin use.
// - Async clock-out setting drives bit-rate clock on pin.
// - Status layout, bit 7 down to 0.
// - Flags 7..3 cleared by 0 after reading 1.
// - Transmit-done and received mp bit read-only.
// - Status returns 84 hex on reset, standby.
// - Tx-empty clears by write-0 or data write.
// - Tx-empty sets on disable or shift load.
// - Rx-full sets on clean finished reception.
// - Rx-full clears by write-0 or data read.
// - Error or disabled receive leaves holding untouched.
// - Overrun sets when full; new data dropped.
// - Overrun clears only by write-0 after read, or standby.
// - Transmit-done sets on disable or last bit.
`timescale 1ns/1ps
module sssel_core #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power state
  input wire logic standby,
  // Transmit engine
  input wire logic tx_shift_load,
  input wire logic tx_last_bit,
  output logic [DATA_W-1:0] tx_data,
  output logic tx_data_valid,
  output logic tx_enable,
  output logic tx_mp_bit,
  // Receive engine
  input wire logic rx_done,
  input wire logic rx_frame_err,
  input wire logic rx_parity_err,
  input wire logic rx_mp_bit,
  input wire logic [DATA_W-1:0] rx_word,
  output logic rx_enable,
  // Clock control
  input wire logic bit_half_tick,
  output logic [1:0] clock_source,
  output logic sync_mode,
  output logic ext_clk_tick,
  // Serial clock pin
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  // Interrupt request
  output logic tx_end_irq
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (DATA_W < 1 || DATA_W > 8) begin : g_bad_width
    $error("DATA_W must lie between 1 and 8");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [DATA_W-1:0] tx_hold;
    logic [DATA_W-1:0] rx_hold;
    logic [7:0] status;
    logic [4:0] armed;
    logic [31:0] rdata;
    logic [1:0] pin_sync;
    logic pin_prev;
    logic ext_tick;
    logic clk_out;
  } sssel_state_s;

  sssel_state_s st;
  sssel_state_s next_st;

  logic setup;
  logic access;
  logic wr_status;
  logic wr_control;
  logic wr_tx_hold;
  logic rd_status;
  logic rd_rx_hold;
  logic mapped;
  logic te;
  logic re;
  logic tx_empty_clr;
  logic rx_ok;

  // Bus phase and address decode
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign mapped = (paddr == sssel_pkg::OFS_STATUS) || (paddr == sssel_pkg::OFS_CONTROL) ||
                  (paddr == sssel_pkg::OFS_TX_HOLD) || (paddr == sssel_pkg::OFS_RX_HOLD);
  assign wr_status = access && pwrite && (paddr == sssel_pkg::OFS_STATUS);
  assign wr_control = access && pwrite && (paddr == sssel_pkg::OFS_CONTROL);
  assign wr_tx_hold = access && pwrite && (paddr == sssel_pkg::OFS_TX_HOLD);
  assign rd_status = access && !pwrite && (paddr == sssel_pkg::OFS_STATUS);
  assign rd_rx_hold = access && !pwrite && (paddr == sssel_pkg::OFS_RX_HOLD);
  assign te = st.ctrl[sssel_pkg::CT_TX_EN];
  assign re = st.ctrl[sssel_pkg::CT_RX_EN];

  // Tx-empty clear by armed write-0 or new holding data
  assign tx_empty_clr = (wr_status && st.armed[sssel_pkg::ST_TX_EMPTY-3] &&
                         !pwdata[sssel_pkg::ST_TX_EMPTY]) || wr_tx_hold;
  // Clean reception accepted only while receiving
  assign rx_ok = rx_done && re && !rx_frame_err && !rx_parity_err;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.ext_tick = 1'b0;

    // Control register write
    if (wr_control) begin
      next_st.ctrl = pwdata[7:0] & 8'hB7;
    end

    // Transmit holding data
    if (wr_tx_hold) begin
      next_st.tx_hold = pwdata[DATA_W-1:0];
    end

    // Write-0 clears of the armed flags; set terms below win
    if (wr_status) begin
      for (int i = 3; i < 8; i++) begin
        if (st.armed[i-3] && !pwdata[i]) begin
          next_st.status[i] = 1'b0;
        end
      end
      next_st.status[sssel_pkg::ST_MP_TX] = pwdata[sssel_pkg::ST_MP_TX];
      next_st.armed = 5'h00;
    end
    if (rd_status) begin
      // Arm only what the bus returned, not a flag set since setup
      next_st.armed = st.rdata[7:3];
    end

    // Tx-empty and transmit-done clear together
    if (tx_empty_clr) begin
      next_st.status[sssel_pkg::ST_TX_EMPTY] = 1'b0;
      next_st.status[sssel_pkg::ST_TX_DONE] = 1'b0;
    end
    if (!te || tx_shift_load) begin
      next_st.status[sssel_pkg::ST_TX_EMPTY] = 1'b1;
    end
    if (!te || (tx_last_bit && st.status[sssel_pkg::ST_TX_EMPTY])) begin
      next_st.status[sssel_pkg::ST_TX_DONE] = 1'b1;
    end

    // Reading the receive holding register empties it
    if (rd_rx_hold) begin
      next_st.status[sssel_pkg::ST_RX_FULL] = 1'b0;
    end

    // Reception outcome
    if (rx_done && re) begin
      if (rx_frame_err) begin
        next_st.status[sssel_pkg::ST_FRAMING] = 1'b1;
      end
      if (rx_parity_err) begin
        next_st.status[sssel_pkg::ST_PARITY] = 1'b1;
      end
    end
    if (rx_ok) begin
      if (st.status[sssel_pkg::ST_RX_FULL]) begin
        next_st.status[sssel_pkg::ST_OVERRUN] = 1'b1;
      end else begin
        next_st.rx_hold = rx_word;
        next_st.status[sssel_pkg::ST_RX_FULL] = 1'b1;
        next_st.status[sssel_pkg::ST_MP_RX] = rx_mp_bit;
      end
    end

    // Standby reinitialises the status register
    if (standby) begin
      next_st.status = sssel_pkg::STATUS_RESET;
      next_st.armed = 5'h00;
    end

    // Read data captured in the setup cycle
    next_st.rdata = 32'h0000_0000;
    if (setup && !pwrite) begin
      case (paddr)
        sssel_pkg::OFS_STATUS: next_st.rdata = {24'h00_0000, st.status};
        sssel_pkg::OFS_CONTROL: next_st.rdata = {24'h00_0000, st.ctrl};
        sssel_pkg::OFS_TX_HOLD: next_st.rdata[DATA_W-1:0] = st.tx_hold;
        sssel_pkg::OFS_RX_HOLD: next_st.rdata[DATA_W-1:0] = st.rx_hold;
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end else if (access) begin
      next_st.rdata = st.rdata;
    end

    // Serial clock pin sampling and rising-edge detect
    next_st.pin_sync = {st.pin_sync[0], serial_clock_pin_in};
    next_st.pin_prev = st.pin_sync[1];
    if (st.ctrl[sssel_pkg::CT_CLK_HI] && st.pin_sync[1] && !st.pin_prev) begin
      next_st.ext_tick = 1'b1;
    end

    // Bit-rate clock output, toggled each half bit
    if (bit_half_tick) begin
      next_st.clk_out = !st.clk_out;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.ctrl <= sssel_pkg::CONTROL_RESET;
      st.status <= sssel_pkg::STATUS_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = st.rdata;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign tx_data = st.tx_hold;
  assign tx_data_valid = !st.status[sssel_pkg::ST_TX_EMPTY];
  assign tx_enable = te;
  assign rx_enable = re;
  assign tx_mp_bit = st.status[sssel_pkg::ST_MP_TX];
  assign clock_source = {st.ctrl[sssel_pkg::CT_CLK_HI], st.ctrl[sssel_pkg::CT_CLK_LO]};
  assign sync_mode = st.ctrl[sssel_pkg::CT_SYNC_MODE];
  assign ext_clk_tick = st.ext_tick;

  // Pin drives a clock in async clock-out or sync internal mode
  assign serial_clock_pin_oe = (clock_source == sssel_pkg::CKS_INT_OUT && !sync_mode) ||
                               (clock_source == sssel_pkg::CKS_INTERNAL && sync_mode);
  assign serial_clock_pin_out = st.clk_out;

  // Request follows flag and enable
  assign tx_end_irq = st.status[sssel_pkg::ST_TX_DONE] &&
                      st.ctrl[sssel_pkg::CT_TX_END_IE];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_irq_follows;
    te && tx_last_bit && st.status[7] && st.ctrl[2] && !wr_control |=> tx_end_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq mismatch");

  property p_irq_drop_on_enable_clear;
    wr_control && !pwdata[2] |=> !tx_end_irq;
  endproperty
  a_irq_drop_on_enable_clear: assert property (p_irq_drop_on_enable_clear)
    else $error("irq stayed after enable clear");

  property p_done_on_last_bit;
    te && tx_last_bit && st.status[7] && !tx_empty_clr |=> st.status[2];
  endproperty
  a_done_on_last_bit: assert property (p_done_on_last_bit)
    else $error("done flag not set on last bit");

  property p_write_one_no_effect;
    wr_status && pwdata[5] && !rx_ok && !standby && st.status[5] |=> st.status[5];
  endproperty
  a_write_one_no_effect: assert property (p_write_one_no_effect)
    else $error("write of one altered overrun");

  property p_clear_needs_read;
    wr_status && !st.armed[3] && st.status[6] && !rd_rx_hold && !standby |=> st.status[6];
  endproperty
  a_clear_needs_read: assert property (p_clear_needs_read)
    else $error("rx full cleared without prior read");

  property p_tx_write_clears_empty;
    wr_tx_hold && te && !tx_shift_load && !tx_last_bit && !standby
      |=> !st.status[7] && !st.status[2];
  endproperty
  a_tx_write_clears_empty: assert property (p_tx_write_clears_empty)
    else $error("tx empty not cleared by data write");

  property p_empty_held_disabled;
    !te && !wr_control |=> st.status[7] [*2];
  endproperty
  a_empty_held_disabled: assert property (p_empty_held_disabled)
    else $error("tx empty low while disabled");

  property p_rx_load;
    rx_ok && !st.status[6] && !standby |=> st.status[6] && st.rx_hold == $past(rx_word);
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("rx word not loaded");

  property p_overrun_keeps_data;
    rx_ok && st.status[6] && !standby |=> st.status[5] && $stable(st.rx_hold);
  endproperty
  a_overrun_keeps_data: assert property (p_overrun_keeps_data)
    else $error("overrun mishandled");

  property p_error_leaves_hold;
    rx_done && (rx_frame_err || rx_parity_err || !re) && !rd_rx_hold && !wr_status && !standby
      |=> $stable(st.rx_hold) && st.status[6] == $past(st.status[6]);
  endproperty
  a_error_leaves_hold: assert property (p_error_leaves_hold)
    else $error("errored reception changed holding");

  property p_standby_status;
    standby |=> st.status == 8'h84;
  endproperty
  a_standby_status: assert property (p_standby_status) else $error("standby reset");

  property p_pin_drive;
    clock_source == 2'h1 && !sync_mode |-> serial_clock_pin_oe;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("clock pin not driven");

  cover_irq: cover property (tx_end_irq);
  cover_overrun: cover property (rx_ok && st.status[6]);
  cover_clear_flow: cover property (rd_status ##[1:20] wr_status);
  cover_ext_tick: cover property (ext_clk_tick);

endmodule

// ==== tb/sssel_peer.sv ====
`timescale 1ns/1ps
module sssel_peer (
  // System clock
  input wire logic pclk,
  // Engine strobes
  output logic tx_shift_load,
  output logic tx_last_bit,
  output logic rx_done,
  output logic rx_frame_err,
  output logic rx_parity_err,
  output logic [7:0] rx_word,
  output logic rx_mp_bit,
  output logic bit_half_tick,
  // Far-side clock, still between bursts
  output logic link_clk
);
  // Idle levels
  initial begin
    {tx_shift_load, tx_last_bit, rx_done, rx_frame_err, rx_parity_err} = '0;
    {bit_half_tick, link_clk, rx_mp_bit} = '0;
    rx_word = 8'h00;
  end
  // Holding data moved into the shift stage
  task automatic load();
    @(posedge pclk);
    tx_shift_load <= 1'b1;
    @(posedge pclk);
    tx_shift_load <= 1'b0;
  endtask
  // Final bit of a character leaves
  task automatic last();
    @(posedge pclk);
    tx_last_bit <= 1'b1;
    @(posedge pclk);
    tx_last_bit <= 1'b0;
  endtask
  // Finished character; released lines show the inverse
  task automatic recv(input logic [7:0] w, input logic fe, input logic pe, input logic mp);
    @(posedge pclk);
    rx_done <= 1'b1;
    rx_word <= w;
    rx_mp_bit <= mp;
    rx_frame_err <= fe;
    rx_parity_err <= pe;
    @(posedge pclk);
    rx_done <= 1'b0;
    rx_word <= ~w;
    rx_frame_err <= ~fe;
    rx_parity_err <= ~pe;
    rx_mp_bit <= ~mp;
  endtask
  // Half-bit pulses from the rate generator
  task automatic half_ticks(input int n);
    repeat (n) begin
      repeat (3) @(posedge pclk);
      bit_half_tick <= 1'b1;
      @(posedge pclk);
      bit_half_tick <= 1'b0;
    end
  endtask
  // External clock burst at the bit rate
  task automatic burst(input int n);
    #37;
    repeat (n) begin
      link_clk = 1'b1;
      #200;
      link_clk = 1'b0;
      #200;
    end
  endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin tests_run++; if ((ac) !== (ex)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, ac); end end
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, standby, err;
  logic [7:0] paddr, rx_word, tx_data;
  logic [31:0] pwdata, prdata, rd;
  logic tx_shift_load, tx_last_bit, rx_done, rx_frame_err, rx_parity_err, rx_mp_bit;
  logic bit_half_tick, link_clk, tx_data_valid, tx_enable, tx_mp_bit, rx_enable;
  logic [1:0] clock_source;
  logic sync_mode, ext_clk_tick, serial_clock_pin_in, serial_clock_pin_out;
  logic serial_clock_pin_oe, tx_end_irq, last_out;
  int st, armed, ctl, rxh, miscompares, tests_run, ticks, tog, seed, r;
  bit oe;

  sssel_core sssel_core_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .standby, .tx_shift_load, .tx_last_bit,
    .tx_data, .tx_data_valid, .tx_enable, .tx_mp_bit, .rx_done, .rx_frame_err,
    .rx_parity_err, .rx_mp_bit, .rx_word, .rx_enable, .bit_half_tick,
    .clock_source, .sync_mode, .ext_clk_tick, .serial_clock_pin_in,
    .serial_clock_pin_out, .serial_clock_pin_oe, .tx_end_irq);
  sssel_peer sssel_peer_inst (.pclk, .tx_shift_load, .tx_last_bit, .rx_done,
    .rx_frame_err, .rx_parity_err, .rx_word, .rx_mp_bit, .bit_half_tick, .link_clk);
  // Pin level: core drives when enabled, else the far side
  assign serial_clock_pin_in = serial_clock_pin_oe ? serial_clock_pin_out : link_clk;

  // Clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Count tick pulses and driven pin toggles
  always @(negedge pclk) begin
    if (ext_clk_tick === 1'b1) ticks++;
    if (serial_clock_pin_oe === 1'b1 && serial_clock_pin_out !== last_out) tog++;
    last_out <= serial_clock_pin_out;
  end

  // ------
  // Bus and model helpers
  // ------
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One APB transfer; answer taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Tx disabled pins empty and done high
  task automatic hold();
    if (!ctl[5]) st = st | 'h84;
  endtask
  task automatic rd_st();
    apb(0, sssel_pkg::OFS_STATUS, 0);
    `CHK("status", st, rd)
    armed = st;
  endtask
  task automatic wr_st(input int v);
    apb(1, sssel_pkg::OFS_STATUS, v);
    st = st & ~(armed & ~v & 'hF8);
    st = (st & ~1) | (v & 1);
    armed = 0;
    hold();
  endtask
  task automatic wr_ct(input int v);
    apb(1, sssel_pkg::OFS_CONTROL, v);
    ctl = v & 'hB7;
    hold();
  endtask
  task automatic wr_tx(input int v);
    apb(1, sssel_pkg::OFS_TX_HOLD, v);
    st = st & ~'h84;
    hold();
    `CHK("tx data", v[7:0], tx_data)
  endtask
  task automatic rd_rx();
    apb(0, sssel_pkg::OFS_RX_HOLD, 0);
    `CHK("rx hold", rxh, rd)
    st = st & ~'h40;
  endtask
  task automatic rx(input int w, input bit fe, input bit pe);
    sssel_peer_inst.recv(w[7:0], fe, pe, w[8]);
    if (ctl[4] && (fe || pe)) st = st | (fe << 4) | (pe << 3);
    else if (ctl[4] && st[6]) st = st | 'h20;
    else if (ctl[4]) begin
      rxh = w[7:0];
      st = st | 'h40;
      st = (st & ~'h2) | (w[8] << 1);
    end
  endtask
  // Port levels against the model, settled at mid-cycle
  task automatic outs();
    @(negedge pclk);
    `CHK("irq", st[2] & ctl[2], tx_end_irq)
    `CHK("tx valid", !st[7], tx_data_valid)
    `CHK("enables", ctl[5:4], {tx_enable, rx_enable})
    `CHK("mp send", st[0], tx_mp_bit)
    @(posedge pclk);
  endtask

  // ------
  // Main sequence
  // ------
  initial begin
    #2000000;
    miscompares++;
    close_out();
  end
  initial begin
    seed = 32'h12df;
    {presetn, psel, penable, pwrite, standby, last_out} = '0;
    paddr = 8'h00;
    pwdata = '0;
    {st, ctl, armed, rxh, tests_run, miscompares, ticks, tog} = '0;
    st = 'h84;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd_st();
    apb(0, sssel_pkg::OFS_CONTROL, 0);
    `CHK("control", 0, rd)
    outs();
    wr_ct('h24);
    outs();
    wr_tx('hA5);
    outs();
    sssel_peer_inst.load();
    st = st | 'h80;
    wr_st(0);
    rd_st();
    wr_st('h05);
    sssel_peer_inst.last();
    rd_st();
    sssel_peer_inst.load();
    st = st | 'h80;
    sssel_peer_inst.last();
    st = st | 'h04;
    outs();
    wr_ct('h20);
    outs();
    wr_tx('h3C);
    wr_ct('h00);
    rd_st();
    wr_ct('h10);
    rx('h5A, 0, 0);
    rd_st();
    rd_rx();
    rx('h111, 0, 0);
    rx('h22, 0, 0);
    rx('h33, 1, 0);
    rx('h44, 0, 1);
    rd_st();
    wr_ct('h00);
    rx('h55, 0, 0);
    rd_rx();
    rd_st();
    wr_st(0);
    rd_st();
    wr_ct('h10);
    repeat (12) begin
      r = $random(seed);
      rx(r, r[8] & r[9], r[10] & r[11]);
      if (r[12]) rd_rx();
      if (r[13]) rd_st();
      if (r[14]) wr_st(r[7:0]);
    end
    rd_st();
    standby <= 1'b1;
    @(posedge pclk);
    standby <= 1'b0;
    st = 'h84;
    armed = 0;
    rd_st();
    apb(1, 8'h10, 'hFF);
    `CHK("slverr", 1, err)
    apb(0, 8'h10, 0);
    `CHK("unmapped", 0, rd)
    for (int c = 0; c < 3; c++) for (int s = 0; s < 2; s++) begin
      if (s == 1 && c == 1) continue;
      wr_ct(c);
      wr_ct(c | s << 7);
      oe = (c == 1 && s == 0) || (c == 0 && s == 1);
      `CHK("clk src", c[1:0], clock_source)
      `CHK("pin oe", oe, serial_clock_pin_oe)
      `CHK("sync mode", s, sync_mode)
      ticks = 0;
      tog = 0;
      fork
        sssel_peer_inst.half_ticks(4);
        sssel_peer_inst.burst(4);
      join
      repeat (8) @(posedge pclk);
      `CHK("ext ticks", (c == 2) ? 4 : 0, ticks)
      `CHK("pin toggles", oe ? 4 : 0, tog)
    end
    close_out();
  end
endmodule
